// file: rtl/ppc_pipe_phy_channel.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] One, two or four lanes at 2.5 Gbps
// [R2] Hard block mode: 8-bit path, 250 MHz
// [R3] Soft mode 16/2 bits, hard mode 8/1
// [R4] Ports match PIPE 2.00 signal set
// [R5] Far side supplies MAC and upper layers
// [R6] Low power states only idle transmitter
// [R7] Far side tri-states output, supplies detection clock
// [R8] Idle request leads detect request by ten
// [R9] Detect done: PhyStatus, status 011 or 000
// [R10] Idle request holds transmitter idle
// [R11] Idle reached within 8 ns
// [R12] Idle lasts at least 20 ns
// [R13] RxElecIdle is inverted signal detect
// [R14] Four commas give lane lock
// [R15] Seventeen errors drop lock
// [R16] Sixteen good groups decrement error count
// [R17] Aligner matches 10-bit patterns only
// [R18] Rate match absorbs 300 ppm each side
// [R19] One SKP added or removed per set
// [R20] Skip set: comma plus 1 to 5 SKP
// [R21] Rate matching waits for lock
// [R22] Add and remove events reported in status
// [R23] Add 001, remove 010, alongside data
module ppc_pipe_phy_channel #(
  parameter int LANES = 1,
  parameter bit HARD_IP = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Transmit from MAC
  input wire logic [LANES*(HARD_IP ? 8 : 16)-1:0] tx_data,
  input wire logic [LANES*(HARD_IP ? 1 : 2)-1:0] tx_data_k,
  input wire logic [LANES-1:0] tx_detect_rx_loopback, // see [R4]
  input wire logic [LANES-1:0] tx_elec_idle,
  input wire logic [LANES-1:0] tx_compliance,
  input wire logic [LANES-1:0] receive_polarity_invert,
  input wire logic [2*LANES-1:0] power_down,
  // Receive to MAC
  output logic [LANES*(HARD_IP ? 8 : 16)-1:0] rx_data,
  output logic [LANES*(HARD_IP ? 1 : 2)-1:0] rx_data_k,
  output logic [LANES-1:0] rx_valid,
  output logic [LANES-1:0] rx_word_strobe,
  output logic [LANES-1:0] phy_status,
  output logic [LANES-1:0] rx_elec_idle,
  output logic [3*LANES-1:0] rx_status,
  output logic tx_word_accept,
  // PMA receive
  input wire logic [10*LANES-1:0] pma_rx_code,
  input wire logic [9*LANES-1:0] pma_rx_sym,
  input wire logic [LANES-1:0] pma_rx_code_err,
  input wire logic [LANES-1:0] pma_rx_sym_en,
  input wire logic [LANES-1:0] pma_signal_detect,
  input wire logic [LANES-1:0] pma_detect_done,
  input wire logic [LANES-1:0] pma_detect_found,
  // PMA transmit
  output logic [9*LANES-1:0] pma_tx_sym,
  output logic [LANES-1:0] pma_tx_elec_idle,
  output logic [LANES-1:0] pma_tx_compliance,
  output logic [LANES-1:0] pma_polarity_invert,
  output logic [LANES-1:0] pma_detect_start,
  output logic [LANES-1:0] pma_loopback_en
);
  localparam int DW = HARD_IP ? 8 : 16; // see [R2] [R3]
  localparam int KW = DW / 8;
  localparam logic [2:0] IDLE_HOLD = 3'(ppc_pkg::IDLE_MIN_CYC - 1);
  localparam logic [3:0] LEAD = 4'(ppc_pkg::DETECT_LEAD_CYC);

  generate
    if (LANES != 1 && LANES != 2 && LANES != 4) begin : g_chk_lanes
      $error("Lane count must be 1, 2 or 4"); // see [R1]
    end
    if (ppc_pkg::EIOS_IDLE_MAX_CYC < 1 || ppc_pkg::IDLE_MIN_CYC > 8) begin : g_chk_idle
      $error("Idle timing does not fit the idle counter");
    end
  endgenerate

  // Transmit word phase shared by all lanes
  logic tx_phase_ff;
  wire nxt_tx_phase = (KW == 2) ? !tx_phase_ff : 1'b0;

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_phase_ff <= 1'b0;
      tx_word_accept <= 1'b0;
    end else begin
      tx_phase_ff <= nxt_tx_phase;
      tx_word_accept <= !nxt_tx_phase;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      ppc_sym_if sym_bus ();
      logic sync_ok;
      logic [8:0] tx_hold_ff;
      logic [2:0] idle_cnt_ff;
      logic [3:0] lead_cnt_ff;
      logic [1:0] pd_prev_ff;
      ppc_pkg::ppc_det_e det_ff;
      ppc_pkg::ppc_det_e nxt_det;
      logic slot_ff;
      logic [8:0] lo_ff;
      logic add_acc_ff;
      logic del_acc_ff;
      logic err_acc_ff;
      wire [1:0] pd = power_down[2*g +: 2];
      wire [8:0] tx_lo = {tx_data_k[g*KW], tx_data[g*DW +: 8]};
      wire [8:0] tx_hi = {tx_data_k[g*KW+KW-1], tx_data[g*DW+DW-8 +: 8]};
      wire want_idle = tx_elec_idle[g] || (pd != ppc_pkg::PD_P0); // see [R6] [R10]
      wire idle_hold = pma_tx_elec_idle[g] && (idle_cnt_ff < IDLE_HOLD); // see [R12]
      wire det_go = tx_detect_rx_loopback[g] && (pd == ppc_pkg::PD_P1) && (lead_cnt_ff == LEAD); // see [R8]
      wire det_finish = (det_ff == ppc_pkg::DET_RUN) && pma_detect_done[g];
      wire pd_change = (pd != pd_prev_ff);
      wire emit = sym_bus.valid && ((KW == 1) || slot_ff);
      wire any_add = add_acc_ff || sym_bus.added;
      wire any_del = del_acc_ff || sym_bus.removed;
      wire any_err = err_acc_ff || sym_bus.err;
      wire [2:0] word_status = any_del ? ppc_pkg::ST_SKP_DEL : // see [R23]
                               (any_add ? ppc_pkg::ST_SKP_ADD :
                               (any_err ? ppc_pkg::ST_DEC_ERR : ppc_pkg::ST_OK));
      wire [2:0] det_status = pma_detect_found[g] ? ppc_pkg::ST_RX_FOUND : ppc_pkg::ST_OK; // see [R9]
      wire [DW-1:0] word_data;
      wire [KW-1:0] word_k;

      if (KW == 2) begin : g_wide
        assign word_data = {sym_bus.sym[7:0], lo_ff[7:0]};
        assign word_k = {sym_bus.sym[8], lo_ff[8]};
      end else begin : g_narrow
        assign word_data = sym_bus.sym[7:0];
        assign word_k = sym_bus.sym[8];
      end

      ppc_sync_fsm u_sync (
        .clock(clock),
        .reset(reset),
        .in_en(pma_rx_sym_en[g]),
        .in_code(pma_rx_code[10*g +: 10]),
        .in_err(pma_rx_code_err[g]),
        .sync_ok(sync_ok)
      );

      ppc_rate_match #(.DEPTH(ppc_pkg::RM_DEPTH)) u_rm (
        .clock(clock),
        .reset(reset),
        .in_en(pma_rx_sym_en[g]),
        .in_sym(pma_rx_sym[9*g +: 9]),
        .in_err(pma_rx_code_err[g]),
        .sync_ok(sync_ok),
        .out(sym_bus.src)
      );

      // Detect sequencing
      always_comb begin
        nxt_det = det_ff;
        case (det_ff)
          ppc_pkg::DET_IDLE: nxt_det = det_go ? ppc_pkg::DET_RUN : ppc_pkg::DET_IDLE;
          ppc_pkg::DET_RUN: nxt_det = pma_detect_done[g] ? ppc_pkg::DET_WAIT_DROP : ppc_pkg::DET_RUN;
          ppc_pkg::DET_WAIT_DROP: nxt_det = tx_detect_rx_loopback[g] ? ppc_pkg::DET_WAIT_DROP : ppc_pkg::DET_IDLE;
          default: nxt_det = ppc_pkg::DET_IDLE;
        endcase
      end

      // Transmit side
      always_ff @(posedge clock) begin
        if (reset) begin
          tx_hold_ff <= 9'h000;
          pma_tx_sym[9*g +: 9] <= 9'h000;
          pma_tx_elec_idle[g] <= 1'b1;
          idle_cnt_ff <= 3'h0;
          lead_cnt_ff <= 4'h0;
          pma_tx_compliance[g] <= 1'b0;
          pma_polarity_invert[g] <= 1'b0;
          pma_loopback_en[g] <= 1'b0;
        end else begin
          if (!tx_phase_ff) begin
            tx_hold_ff <= tx_hi;
          end
          pma_tx_sym[9*g +: 9] <= tx_phase_ff ? tx_hold_ff : tx_lo;
          pma_tx_elec_idle[g] <= want_idle || idle_hold; // see [R10] [R11] [R12]
          idle_cnt_ff <= !pma_tx_elec_idle[g] ? 3'h0 : (idle_hold ? idle_cnt_ff + 3'h1 : idle_cnt_ff);
          lead_cnt_ff <= !tx_elec_idle[g] ? 4'h0 : ((lead_cnt_ff == LEAD) ? LEAD : lead_cnt_ff + 4'h1);
          pma_tx_compliance[g] <= tx_compliance[g];
          pma_polarity_invert[g] <= receive_polarity_invert[g];
          pma_loopback_en[g] <= tx_detect_rx_loopback[g] && (pd == ppc_pkg::PD_P0) && !tx_elec_idle[g];
        end
      end

      // Detect and power state reporting
      always_ff @(posedge clock) begin
        if (reset) begin
          det_ff <= ppc_pkg::DET_IDLE;
          pma_detect_start[g] <= 1'b0;
          pd_prev_ff <= ppc_pkg::PD_P0;
          phy_status[g] <= 1'b0;
        end else begin
          det_ff <= nxt_det;
          pma_detect_start[g] <= (nxt_det == ppc_pkg::DET_RUN);
          pd_prev_ff <= pd;
          phy_status[g] <= det_finish || pd_change; // see [R9]
        end
      end

      // Receive word assembly
      always_ff @(posedge clock) begin
        if (reset) begin
          slot_ff <= 1'b0;
          lo_ff <= 9'h000;
          add_acc_ff <= 1'b0;
          del_acc_ff <= 1'b0;
          err_acc_ff <= 1'b0;
          rx_data[g*DW +: DW] <= '0;
          rx_data_k[g*KW +: KW] <= '0;
          rx_status[3*g +: 3] <= ppc_pkg::ST_OK;
          rx_word_strobe[g] <= 1'b0;
          rx_valid[g] <= 1'b0;
          rx_elec_idle[g] <= 1'b1;
        end else begin
          rx_valid[g] <= sync_ok;
          rx_elec_idle[g] <= !pma_signal_detect[g]; // see [R13]
          rx_word_strobe[g] <= emit;
          if (sym_bus.valid && !emit) begin
            slot_ff <= 1'b1;
            lo_ff <= sym_bus.sym;
            add_acc_ff <= sym_bus.added;
            del_acc_ff <= sym_bus.removed;
            err_acc_ff <= sym_bus.err;
          end else if (emit) begin
            slot_ff <= 1'b0;
            add_acc_ff <= 1'b0;
            del_acc_ff <= 1'b0;
            err_acc_ff <= 1'b0;
            rx_data[g*DW +: DW] <= word_data;
            rx_data_k[g*KW +: KW] <= word_k;
          end
          if (det_finish) begin
            rx_status[3*g +: 3] <= det_status; // see [R9]
          end else if (emit) begin
            rx_status[3*g +: 3] <= word_status; // see [R22] [R23]
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: rtl/ppc_pkg.sv
package ppc_pkg;
  // Comma and skip code groups
  localparam logic [9:0] COMMA_NEG = 10'h0FA;
  localparam logic [9:0] COMMA_POS = 10'h305;
  localparam logic [8:0] SYM_COM = 9'h1BC;
  localparam logic [8:0] SYM_SKP = 9'h11C;
  localparam int SKP_MAX_RUN = 5;
  // Receive status codes
  localparam logic [2:0] ST_OK = 3'h0;
  localparam logic [2:0] ST_SKP_ADD = 3'h1;
  localparam logic [2:0] ST_SKP_DEL = 3'h2;
  localparam logic [2:0] ST_RX_FOUND = 3'h3;
  localparam logic [2:0] ST_DEC_ERR = 3'h4;
  // Power states
  localparam logic [1:0] PD_P0 = 2'h0;
  localparam logic [1:0] PD_P0S = 2'h1;
  localparam logic [1:0] PD_P1 = 2'h2;
  localparam logic [1:0] PD_P2 = 2'h3;
  // Line and compensation figures
  localparam int LINE_RATE_MBPS = 2500;
  localparam int PPM_EACH_SIDE = 300;
  localparam int RM_DEPTH = 8;
  // Synchronisation counts
  localparam int SYNC_ACQ_COMMAS = 4;
  localparam int SYNC_LOSS_ERRORS = 17;
  localparam int SYNC_GOOD_RUN = 16;
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int IDLE_MIN_NS = 20;
  localparam int IDLE_MIN_CYC = (IDLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EIOS_IDLE_MAX_NS = 8;
  localparam int EIOS_IDLE_MAX_RAW = (EIOS_IDLE_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int EIOS_IDLE_MAX_CYC = (EIOS_IDLE_MAX_RAW < 1) ? 1 : EIOS_IDLE_MAX_RAW;
  localparam int DETECT_LEAD_CYC = 10;
  // State types
  typedef enum logic {SYNC_LOST, SYNC_LOCK} ppc_sync_e;
  typedef enum logic [1:0] {DET_IDLE, DET_RUN, DET_WAIT_DROP} ppc_det_e;
endpackage

// file: rtl/ppc_sym_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ppc_sym_if;
  logic valid;
  logic [8:0] sym;
  logic err;
  logic added;
  logic removed;
  modport src(output valid, output sym, output err, output added, output removed);
  modport dst(input valid, input sym, input err, input added, input removed);
endinterface
`default_nettype wire

// file: rtl/ppc_sync_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_sync_fsm (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Code groups
  input wire logic in_en,
  input wire logic [9:0] in_code,
  input wire logic in_err,
  // Lock
  output logic sync_ok
);
  ppc_pkg::ppc_sync_e state_ff;
  logic [4:0] comma_cnt_ff;
  logic [4:0] err_cnt_ff;
  logic [4:0] good_cnt_ff;

  wire is_comma = (in_code == ppc_pkg::COMMA_NEG) || (in_code == ppc_pkg::COMMA_POS); // see [R17]
  wire acq_done = is_comma && !in_err && (comma_cnt_ff == 5'(ppc_pkg::SYNC_ACQ_COMMAS - 1)); // see [R14]
  wire err_lost = in_err && (err_cnt_ff == 5'(ppc_pkg::SYNC_LOSS_ERRORS - 1)); // see [R15]
  wire good_run = !in_err && (good_cnt_ff == 5'(ppc_pkg::SYNC_GOOD_RUN - 1)); // see [R16]

  assign sync_ok = (state_ff == ppc_pkg::SYNC_LOCK);

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= ppc_pkg::SYNC_LOST;
      comma_cnt_ff <= 5'h00;
      err_cnt_ff <= 5'h00;
      good_cnt_ff <= 5'h00;
    end else if (in_en) begin
      case (state_ff)
        ppc_pkg::SYNC_LOST: begin
          err_cnt_ff <= 5'h00;
          good_cnt_ff <= 5'h00;
          if (in_err) begin
            comma_cnt_ff <= 5'h00;
          end else if (acq_done) begin
            comma_cnt_ff <= 5'h00;
            state_ff <= ppc_pkg::SYNC_LOCK;
          end else if (is_comma) begin
            comma_cnt_ff <= comma_cnt_ff + 5'h01;
          end
        end
        ppc_pkg::SYNC_LOCK: begin
          if (err_lost) begin
            state_ff <= ppc_pkg::SYNC_LOST;
          end else if (in_err) begin
            err_cnt_ff <= err_cnt_ff + 5'h01;
            good_cnt_ff <= 5'h00;
          end else if (good_run) begin
            good_cnt_ff <= 5'h00;
            if (err_cnt_ff != 5'h00) begin
              err_cnt_ff <= err_cnt_ff - 5'h01;
            end
          end else begin
            good_cnt_ff <= good_cnt_ff + 5'h01;
          end
        end
        default: state_ff <= ppc_pkg::SYNC_LOST;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: rtl/ppc_rate_match.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_rate_match #(
  parameter int DEPTH = ppc_pkg::RM_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Decoded symbols in
  input wire logic in_en,
  input wire logic [8:0] in_sym,
  input wire logic in_err,
  input wire logic sync_ok,
  // Symbols out
  ppc_sym_if.src out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] LVL_HI = (AW + 1)'(DEPTH / 2 + 1);
  localparam logic [AW:0] LVL_LO = (AW + 1)'(DEPTH / 2 - 1);
  localparam logic [AW:0] LVL_FULL = (AW + 1)'(DEPTH);

  generate
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("Rate match depth must be a power of two of at least 4");
    end
  endgenerate

  // SKP inside an ordered set, one to five after the comma
  function automatic logic skp_in_os(input logic [8:0] s, input logic os, input logic [2:0] run);
    skp_in_os = (s == ppc_pkg::SYM_SKP) && os && (run < 3'(ppc_pkg::SKP_MAX_RUN)); // see [R20]
  endfunction

  logic [10:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic wr_os_ff;
  logic rd_os_ff;
  logic [2:0] wr_run_ff;
  logic [2:0] rd_run_ff;
  logic del_done_ff;
  logic ins_done_ff;
  logic del_pend_ff;

  wire [10:0] head = mem_ff[rd_ptr_ff];
  wire empty = (cnt_ff == '0);
  wire full = (cnt_ff == LVL_FULL);
  wire w_match = skp_in_os(in_sym, wr_os_ff, wr_run_ff);
  wire r_match = skp_in_os(head[8:0], rd_os_ff, rd_run_ff);
  wire w_com = (in_sym == ppc_pkg::SYM_COM);
  wire r_com = (head[8:0] == ppc_pkg::SYM_COM);
  wire drop = in_en && sync_ok && w_match && !del_done_ff && (cnt_ff > LVL_HI); // see [R19] [R21]
  wire push = in_en && !drop && !full;
  wire rep = !empty && sync_ok && r_match && !ins_done_ff && (cnt_ff < LVL_LO); // see [R19] [R21]
  wire pop = !empty && !rep;
  wire [AW:0] nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop); // see [R18]

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= {in_err, del_pend_ff, in_sym};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
      cnt_ff <= nxt_cnt;
    end
  end

  // Ordered set tracking on write side
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_os_ff <= 1'b0;
      wr_run_ff <= 3'h0;
      del_done_ff <= 1'b0;
      del_pend_ff <= 1'b0;
    end else begin
      if (in_en) begin
        wr_os_ff <= w_com || w_match;
        wr_run_ff <= w_com ? 3'h0 : (w_match ? wr_run_ff + 3'h1 : 3'h0);
        del_done_ff <= w_com ? 1'b0 : (drop || del_done_ff);
      end
      if (drop) begin
        del_pend_ff <= 1'b1;
      end else if (push) begin
        del_pend_ff <= 1'b0;
      end
    end
  end

  // Ordered set tracking on read side
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_os_ff <= 1'b0;
      rd_run_ff <= 3'h0;
      ins_done_ff <= 1'b0;
    end else if (pop) begin
      rd_os_ff <= r_com || r_match;
      rd_run_ff <= r_com ? 3'h0 : (r_match ? rd_run_ff + 3'h1 : 3'h0);
      ins_done_ff <= r_com ? 1'b0 : ins_done_ff;
    end else if (rep) begin
      ins_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      out.valid <= 1'b0;
      out.sym <= 9'h000;
      out.err <= 1'b0;
      out.added <= 1'b0;
      out.removed <= 1'b0;
    end else begin
      out.valid <= !empty;
      out.sym <= head[8:0];
      out.err <= head[10] && pop;
      out.added <= rep; // see [R22]
      out.removed <= head[9] && pop; // see [R22]
    end
  end
endmodule
`default_nettype wire

// file: tb/ppc_pipe_phy_channel_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_pipe_phy_channel_chk #(
  parameter int LANES = 1,
  parameter bit HARD_IP = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // MAC side
  input wire logic [LANES*(HARD_IP ? 8 : 16)-1:0] tx_data,
  input wire logic [LANES*(HARD_IP ? 1 : 2)-1:0] tx_data_k,
  input wire logic [LANES-1:0] tx_elec_idle,
  input wire logic [2*LANES-1:0] power_down,
  input wire logic [LANES-1:0] rx_valid,
  input wire logic [LANES-1:0] rx_word_strobe,
  input wire logic [LANES-1:0] phy_status,
  input wire logic [3*LANES-1:0] rx_status,
  input wire logic [LANES-1:0] rx_elec_idle,
  input wire logic tx_word_accept,
  // PMA side
  input wire logic [10*LANES-1:0] pma_rx_code,
  input wire logic [LANES-1:0] pma_rx_sym_en,
  input wire logic [LANES-1:0] pma_signal_detect,
  input wire logic [LANES-1:0] pma_detect_done,
  input wire logic [LANES-1:0] pma_detect_found,
  input wire logic [9*LANES-1:0] pma_tx_sym,
  input wire logic [LANES-1:0] pma_tx_elec_idle,
  input wire logic [LANES-1:0] pma_detect_start
);
  wire comma_in = pma_rx_sym_en[0] && (pma_rx_code[9:0] == ppc_pkg::COMMA_NEG || pma_rx_code[9:0] == ppc_pkg::COMMA_POS);
  wire skp_event = rx_word_strobe[0] && (rx_status[2:0] == ppc_pkg::ST_SKP_ADD || rx_status[2:0] == ppc_pkg::ST_SKP_DEL);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_idle_follows_req: assert property (tx_elec_idle[0] |=> pma_tx_elec_idle[0])
    else $error("transmitter not idle after idle request");
  a_low_power_idle: assert property (power_down[1:0] != ppc_pkg::PD_P0 |=> pma_tx_elec_idle[0])
    else $error("transmitter not idle in low power state");
  a_idle_min_hold: assert property ($rose(pma_tx_elec_idle[0]) |=> pma_tx_elec_idle[0] [*4])
    else $error("electrical idle shorter than five cycles");
  a_rx_idle_inverse: assert property (!$past(reset) |-> rx_elec_idle[0] == !$past(pma_signal_detect[0]))
    else $error("receive idle is not inverted signal detect");
  a_detect_status: assert property (pma_detect_start[0] && pma_detect_done[0] |=> phy_status[0] &&
    rx_status[2:0] == ($past(pma_detect_found[0]) ? ppc_pkg::ST_RX_FOUND : ppc_pkg::ST_OK))
    else $error("wrong detect completion status");
  a_detect_lead_idle: assert property ($rose(pma_detect_start[0]) |->
    $past(tx_elec_idle[0]) && $past(power_down[1:0]) == ppc_pkg::PD_P1)
    else $error("detect started without idle in P1");
  a_tx_first_byte: assert property (tx_word_accept |=>
    pma_tx_sym[8:0] == {$past(tx_data_k[0]), $past(tx_data[7:0])})
    else $error("first transmit symbol wrong");
  a_lock_on_comma: assert property ($rose(rx_valid[0]) |->
    $past(comma_in) || $past(comma_in, 2) || $past(comma_in, 3))
    else $error("lock without a comma");
  a_rm_after_lock: assert property (skp_event |-> rx_valid[0] || $past(rx_valid[0]))
    else $error("skip event while unlocked");
  c_found: cover property (phy_status[0] && rx_status[2:0] == ppc_pkg::ST_RX_FOUND);
  c_skp_event: cover property (skp_event);
  c_lock: cover property ($rose(rx_valid[0]));
endmodule
bind ppc_pipe_phy_channel ppc_pipe_phy_channel_chk #(.LANES(LANES), .HARD_IP(HARD_IP)) ppc_pipe_phy_channel_chk_i (
  .clock(clock), .reset(reset), .tx_data(tx_data), .tx_data_k(tx_data_k), .tx_elec_idle(tx_elec_idle),
  .power_down(power_down), .rx_valid(rx_valid), .rx_word_strobe(rx_word_strobe), .phy_status(phy_status),
  .rx_status(rx_status), .rx_elec_idle(rx_elec_idle), .tx_word_accept(tx_word_accept),
  .pma_rx_code(pma_rx_code), .pma_rx_sym_en(pma_rx_sym_en), .pma_signal_detect(pma_signal_detect),
  .pma_detect_done(pma_detect_done), .pma_detect_found(pma_detect_found), .pma_tx_sym(pma_tx_sym),
  .pma_tx_elec_idle(pma_tx_elec_idle), .pma_detect_start(pma_detect_start)
);
`default_nettype wire

// file: tb/ppc_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_mac_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bench requests
  input wire logic idle_req,
  input wire logic det_req,
  input wire logic no_lead,
  // Channel side
  input wire logic phy_status,
  output logic tx_elec_idle,
  output logic tx_detect_rx_loopback
);
  logic [3:0] lead_ff;
  logic busy_ff;
  logic det_ff;
  logic done_ff;
  wire lead_ok = (lead_ff == 4'hA) || no_lead;
  wire det_end = det_ff && phy_status;
  // Idle raised ahead of detect and held through it
  assign tx_elec_idle = idle_req || busy_ff;
  assign tx_detect_rx_loopback = det_ff;
  always_ff @(posedge clock) begin
    if (reset) begin
      lead_ff <= 4'h0;
      busy_ff <= 1'b0;
      det_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= det_req;
      lead_ff <= !busy_ff ? 4'h0 : (lead_ff == 4'hA ? lead_ff : lead_ff + 4'h1);
      det_ff <= busy_ff && lead_ok && !done_ff && !det_end;
      done_ff <= det_req && (done_ff || det_end);
    end
  end
endmodule
`default_nettype wire

// file: tb/test_ppc_pipe_phy_channel.sv
`timescale 1ns/1ps
`default_nettype none
module test_ppc_pipe_phy_channel;
  localparam logic [9:0] DATA_CODE = 10'h2AA;
  localparam logic [9:0] SKP_CODE = 10'h2F4;
  localparam logic [8:0] DATA_SYM = 9'h0AA;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic [0:0] tx_data_k = 1'h0;
  logic [1:0] power_down = 2'h0;
  logic [9:0] pma_rx_code = 10'h000;
  logic [8:0] pma_rx_sym = 9'h000;
  logic pma_rx_code_err = 1'b0, pma_rx_sym_en = 1'b0, pma_signal_detect = 1'b0;
  logic pma_detect_done = 1'b0, pma_detect_found = 1'b0, tx_compliance = 1'b0, rx_pol = 1'b0;
  logic idle_req = 1'b0, det_req = 1'b0, no_lead = 1'b0;
  logic [8:0] tx_tab [4] = '{9'h1BC, 9'h000, 9'h0FF, 9'h11C};
  wire [7:0] rx_data;
  wire [2:0] rx_status;
  wire [8:0] pma_tx_sym;
  wire rx_data_k, rx_valid, rx_word_strobe, phy_status, rx_elec_idle, tx_word_accept;
  wire pma_tx_elec_idle, pma_detect_start, tx_elec_idle, tx_detect_rx_loopback, pma_cmp, pma_pol;
  int error_cnt = 0, checks_done = 0, cyc = 0, add_cnt = 0, n = 0;

  ppc_pipe_phy_channel #(.LANES(1), .HARD_IP(1'b1)) ppc_pipe_phy_channel_i (
    .clock(clock), .reset(reset), .tx_data(tx_data), .tx_data_k(tx_data_k),
    .tx_detect_rx_loopback(tx_detect_rx_loopback), .tx_elec_idle(tx_elec_idle), .tx_compliance(tx_compliance),
    .receive_polarity_invert(rx_pol), .power_down(power_down), .rx_data(rx_data), .rx_data_k(rx_data_k),
    .rx_valid(rx_valid), .rx_word_strobe(rx_word_strobe), .phy_status(phy_status), .rx_elec_idle(rx_elec_idle),
    .rx_status(rx_status), .tx_word_accept(tx_word_accept), .pma_rx_code(pma_rx_code), .pma_rx_sym(pma_rx_sym),
    .pma_rx_code_err(pma_rx_code_err), .pma_rx_sym_en(pma_rx_sym_en), .pma_signal_detect(pma_signal_detect),
    .pma_detect_done(pma_detect_done), .pma_detect_found(pma_detect_found), .pma_tx_sym(pma_tx_sym),
    .pma_tx_elec_idle(pma_tx_elec_idle), .pma_tx_compliance(pma_cmp), .pma_polarity_invert(pma_pol),
    .pma_detect_start(pma_detect_start), .pma_loopback_en()
  );
  ppc_mac_model ppc_mac_model_i (
    .clock(clock), .reset(reset), .idle_req(idle_req), .det_req(det_req), .no_lead(no_lead),
    .phy_status(phy_status), .tx_elec_idle(tx_elec_idle), .tx_detect_rx_loopback(tx_detect_rx_loopback)
  );

  always #2 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic step(input int k = 1);
    repeat (k) @(posedge clock);
  endtask
  task automatic send(input logic [9:0] code, input logic [8:0] sym, input logic err);
    step();
    pma_rx_sym_en <= 1'b1;
    pma_rx_code <= code;
    pma_rx_sym <= sym;
    pma_rx_code_err <= err;
    step();
    pma_rx_sym_en <= 1'b0;
    step(2);
  endtask
  task automatic skp_set(input int k);
    send(ppc_pkg::COMMA_NEG, ppc_pkg::SYM_COM, 1'b0);
    repeat (k) send(SKP_CODE, ppc_pkg::SYM_SKP, 1'b0);
  endtask
  task automatic groups(input int k, input logic err);
    repeat (k) send(DATA_CODE, DATA_SYM, err);
  endtask

  // Skip insertions seen at the MAC side
  always @(posedge clock) begin
    cyc++;
    if (!reset && rx_word_strobe === 1'b1 && rx_status === ppc_pkg::ST_SKP_ADD) begin
      add_cnt++;
      check(16'({rx_data_k, rx_data}), 16'({1'b1, ppc_pkg::SYM_SKP[7:0]}));
    end
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    step(16);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      step();
      {tx_compliance, rx_pol, tx_data_k, tx_data} <= {2'(i), tx_tab[i]};
      step();
      #1;
      check(16'(pma_tx_sym), 16'(tx_tab[i]));
      check(16'(tx_word_accept), 16'h1);
      check(16'({pma_cmp, pma_pol}), 16'(i));
    end
    $display("Test transmit done");
    step();
    idle_req <= 1'b1;
    step();
    idle_req <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      #1;
      check(16'(pma_tx_elec_idle), 16'(i < 5));
      step();
    end
    for (int p = 1; p < 4; p++) begin
      power_down <= 2'(p);
      step(2);
      #1;
      check(16'(pma_tx_elec_idle), 16'h1);
      step();
      power_down <= ppc_pkg::PD_P0;
      step(8);
      #1;
      check(16'(pma_tx_elec_idle), 16'h0);
      step();
    end
    for (int s = 0; s < 2; s++) begin
      pma_signal_detect <= (s == 0);
      step();
      #1;
      check(16'(rx_elec_idle), 16'(s));
      step();
    end
    $display("Test idle done");
    power_down <= ppc_pkg::PD_P1;
    for (int f = 0; f < 2; f++) begin
      no_lead <= f[0];
      pma_detect_found <= f[0];
      step(4);
      det_req <= 1'b1;
      n = 0;
      while (pma_detect_start !== 1'b1 && n < 60) begin
        step();
        #1;
        n++;
      end
      check(16'(n >= 10 && n < 60), 16'h1);
      step();
      pma_detect_done <= 1'b1;
      step();
      pma_detect_done <= 1'b0;
      #1;
      check(16'({phy_status, rx_status}), 16'({1'b1, f[0] ? ppc_pkg::ST_RX_FOUND : ppc_pkg::ST_OK}));
      step();
      det_req <= 1'b0;
      step(12);
    end
    power_down <= ppc_pkg::PD_P0;
    step(8);
    $display("Test detect done");
    skp_set(1);
    skp_set(2);
    step(8);
    check(16'(add_cnt), 16'h0);
    groups(1, 1'b1);
    repeat (4) send(DATA_CODE, ppc_pkg::SYM_COM, 1'b0);
    repeat (3) send(ppc_pkg::COMMA_POS, ppc_pkg::SYM_COM, 1'b0);
    step(4);
    #1;
    check(16'(rx_valid), 16'h0);
    send(ppc_pkg::COMMA_NEG, ppc_pkg::SYM_COM, 1'b0);
    step(4);
    #1;
    check(16'(rx_valid), 16'h1);
    $display("Test lock done");
    for (int k = 1; k <= ppc_pkg::SKP_MAX_RUN; k++) begin
      n = add_cnt;
      skp_set(k);
      step(8);
      check(16'(add_cnt - n), 16'h1);
    end
    $display("Test rate match done");
    groups(16, 1'b1);
    groups(16, 1'b0);
    groups(1, 1'b1);
    step(4);
    #1;
    check(16'(rx_valid), 16'h1);
    groups(1, 1'b1);
    step(4);
    #1;
    check(16'(rx_valid), 16'h0);
    $display("Test errors done");
    give_verdict();
  end
endmodule
`default_nettype wire
